// ---- core/flh_fault_log.sv ----
/*
 * Fault history log top: parameter access port, ring of entries, read
 * pointer with holding buffer, erase sequencer and drive reaction state.
 * Assumes all inputs come from logic on core_clk and that the parameter
 * master issues one request at a time.
 */
`timescale 1ns/1ps
module flh_fault_log
    import flh_pkg::*;
#(
    parameter int SEC_CYCLES = CYCLES_PER_SEC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire flh_param_req_t param_req,
    output flh_param_rsp_t param_rsp,
    input wire flh_fault_t fault_in,
    input wire logic power_stage_en,
    input wire logic fault_reset_req,
    output logic halt_request,
    output logic [3:0] target_state,
    output logic fault_locked
);

    // Map a severity class onto the operating state it drives toward
    function automatic logic [3:0] sev_target(input logic [15:0] sev);
        logic [3:0] st;
        st = STATE_NONE;
        if (sev == SEV_WARN) begin
            st = STATE_NONE;
        end else if (sev == SEV_ERR_QS7) begin
            st = STATE_QSTOP;
        end else if (sev == SEV_ERR_QS8) begin
            st = STATE_REACT;
        end else begin
            st = STATE_FAULT;
        end
        return st;
    endfunction

    // Context counter values, sampled when a fault arrives
    logic [28:0] op_seconds;
    logic [15:0] en_cycles;
    logic [15:0] since_en_sec;

    // Operating seconds, enable cycles and seconds since enable
    flh_ctx_timer #(
        .SEC_CYCLES(SEC_CYCLES)
    ) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .power_stage_en(power_stage_en),
        .op_seconds(op_seconds),
        .en_cycles(en_cycles),
        .since_en_sec(since_en_sec)
    );

    // Ring storage port
    logic mem_we;
    logic [IDX_W-1:0] mem_widx;
    flh_entry_t mem_wdata;
    logic [IDX_W-1:0] mem_ridx;
    flh_entry_t mem_rdata;

    // Entry ring; the read port is asynchronous so a code read answers in one cycle
    flh_log_mem u_mem (
        .core_clk(core_clk),
        .we(mem_we),
        .widx(mem_widx),
        .wdata(mem_wdata),
        .ridx(mem_ridx),
        .rdata(mem_rdata)
    );

    // Log state
    logic [IDX_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic [CNT_W-1:0] rd_idx_reg, rd_idx_next;
    flh_entry_t hold_reg, hold_next;
    flh_erase_state_t erase_state_reg, erase_state_next;
    logic [IDX_W-1:0] clr_idx_reg, clr_idx_next;
    flh_entry_t pend_reg, pend_next;
    logic pend_valid_reg, pend_valid_next;
    flh_param_rsp_t rsp_reg, rsp_next;

    // Reaction state
    logic [3:0] react_reg, react_next;
    logic halt_reg, halt_next;
    logic locked_reg, locked_next;

    logic [IDX_W-1:0] oldest_idx;
    logic entry_avail;
    logic erasing;
    logic [3:0] new_target;
    logic [15:0] buf_rdata;
    logic buf_hit;

    // Oldest slot sits count entries behind the write pointer
    // A full ring has count 16, whose low bits are zero, so the oldest slot is the write slot
    assign oldest_idx = IDX_W'(wr_ptr_reg - count_reg[IDX_W-1:0]);
    assign mem_ridx = IDX_W'(oldest_idx + rd_idx_reg[IDX_W-1:0]);
    assign erasing = (erase_state_reg == ES_CLEAR);
    assign entry_avail = !erasing && (rd_idx_reg < count_reg);

    // Capture, parameter access, log write and erase sequencing
    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        count_next = count_reg;
        rd_idx_next = rd_idx_reg;
        hold_next = hold_reg;
        erase_state_next = erase_state_reg;
        clr_idx_next = clr_idx_reg;
        pend_next = pend_reg;
        pend_valid_next = pend_valid_reg;
        rsp_next = '0;
        mem_we = 1'b0;
        mem_widx = wr_ptr_reg;
        mem_wdata = pend_reg;

        // Context is frozen on the fault's own cycle, not at write time
        if (fault_in.valid) begin
            pend_next.code = fault_in.code;
            pend_next.severity = fault_in.severity;
            pend_next.timestamp = {3'b000, op_seconds};
            pend_next.on_time = since_en_sec;
            pend_next.current = fault_in.current;
            pend_next.cycles = en_cycles;
            pend_valid_next = 1'b1;
        end

        if (param_req.req) begin
            rsp_next.ack = 1'b1;
            if (param_req.wr) begin
                if (param_req.addr == ADDR_ERASE) begin
                    if (param_req.wdata == CMD_ONE && !erasing) begin
                        erase_state_next = ES_CLEAR;
                        clr_idx_next = '0;
                    end
                end else if (param_req.addr == ADDR_REWIND) begin
                    if (param_req.wdata == CMD_ONE) begin
                        rd_idx_next = '0;
                    end
                end else begin
                    rsp_next.err = 1'b1;
                end
            end else begin
                if (param_req.addr == ADDR_ERASE) begin
                    rsp_next.rdata = {15'h0000, erasing};
                end else if (param_req.addr == ADDR_REWIND) begin
                    rsp_next.rdata = '0;
                end else if (param_req.addr == ADDR_CODE) begin
                    if (entry_avail) begin
                        hold_next = mem_rdata;
                        rd_idx_next = CNT_W'(rd_idx_reg + 1'b1);
                        rsp_next.rdata = mem_rdata.code;
                    end else begin
                        hold_next = '0;
                        rsp_next.rdata = '0;
                    end
                end else if (buf_hit) begin
                    rsp_next.rdata = buf_rdata;
                end else begin
                    rsp_next.err = 1'b1;
                end
            end
        end

        case (erase_state_reg)
            ES_IDLE: begin
                // A full ring drops its oldest entry; the pointer keeps its entry
                if (pend_valid_reg) begin
                    mem_we = 1'b1;
                    wr_ptr_next = IDX_W'(wr_ptr_reg + 1'b1);
                    pend_valid_next = fault_in.valid;
                    if (count_reg != CNT_FULL) begin
                        count_next = CNT_W'(count_reg + 1'b1);
                    end else if (rd_idx_next != '0) begin
                        rd_idx_next = CNT_W'(rd_idx_next - 1'b1);
                    end
                end
            end
            ES_CLEAR: begin
                // One slot per cycle; the latest fault waits in the pending slot meanwhile
                mem_we = 1'b1;
                mem_widx = clr_idx_reg;
                mem_wdata = '0;
                clr_idx_next = IDX_W'(clr_idx_reg + 1'b1);
                if (clr_idx_reg == IDX_LAST) begin
                    erase_state_next = ES_IDLE;
                    wr_ptr_next = '0;
                    count_next = '0;
                    rd_idx_next = '0;
                end
            end
            default: begin
                erase_state_next = ES_IDLE;
            end
        endcase
    end

    // Log, erase and response registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            count_reg <= '0;
            rd_idx_reg <= '0;
            hold_reg <= '0;
            erase_state_reg <= ES_IDLE;
            clr_idx_reg <= '0;
            pend_reg <= '0;
            pend_valid_reg <= 1'b0;
            rsp_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            count_reg <= count_next;
            rd_idx_reg <= rd_idx_next;
            hold_reg <= hold_next;
            erase_state_reg <= erase_state_next;
            clr_idx_reg <= clr_idx_next;
            pend_reg <= pend_next;
            pend_valid_reg <= pend_valid_next;
            rsp_reg <= rsp_next;
        end
    end

    // Buffered components come from the holding register, never from the ring,
    // so a fault logged between two reads cannot tear an entry
    always_comb begin
        buf_hit = 1'b1;
        buf_rdata = '0;
        if (param_req.addr == ADDR_SEVERITY) begin
            buf_rdata = hold_reg.severity;
        end else if (param_req.addr == ADDR_TIME_HI) begin
            buf_rdata = hold_reg.timestamp[31:16];
        end else if (param_req.addr == ADDR_TIME_LO) begin
            buf_rdata = hold_reg.timestamp[15:0];
        end else if (param_req.addr == ADDR_CYCLES) begin
            buf_rdata = hold_reg.cycles;
        end else if (param_req.addr == ADDR_ON_TIME) begin
            buf_rdata = hold_reg.on_time;
        end else if (param_req.addr == ADDR_CURRENT) begin
            buf_rdata = hold_reg.current;
        end else begin
            buf_hit = 1'b0;
        end
    end

    // Target state of the arriving fault's class
    assign new_target = sev_target(fault_in.severity);

    // Reaction: the most severe target sticks; a new fault above warning class beats a reset
    always_comb begin
        react_next = react_reg;
        halt_next = halt_reg;
        locked_next = locked_reg;
        if (fault_in.valid && new_target != STATE_NONE) begin
            if (new_target > react_reg) begin
                react_next = new_target;
            end
            halt_next = 1'b1;
            if (fault_in.severity >= SEV_FATAL_LOCK) begin
                locked_next = 1'b1;
            end
        end else if (fault_reset_req && !locked_reg) begin
            react_next = STATE_NONE;
            halt_next = 1'b0;
        end
    end

    // Reaction registers; only rst releases a lock, a fault reset does not
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            react_reg <= STATE_NONE;
            halt_reg <= 1'b0;
            locked_reg <= 1'b0;
        end else begin
            react_reg <= react_next;
            halt_reg <= halt_next;
            locked_reg <= locked_next;
        end
    end

    // Every output comes straight from a register
    assign param_rsp = rsp_reg;
    assign halt_request = halt_reg;
    assign target_state = react_reg;
    assign fault_locked = locked_reg;

endmodule

// ---- core/flh_pkg.sv ----
/*
 * Shared constants, types and register map of the fault history log.
 * Assumes a single 250 MHz core clock and 16-bit parameter accesses.
 */
package flh_pkg;

    // Log geometry
    localparam int LOG_DEPTH = 16;
    localparam int IDX_W = 4;
    localparam int CNT_W = 5;
    localparam logic [IDX_W-1:0] IDX_LAST = 4'hF;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;

    // Parameter addresses
    localparam logic [15:0] ADDR_ERASE = 16'h3B08;
    localparam logic [15:0] ADDR_REWIND = 16'h3B0A;
    localparam logic [15:0] ADDR_CODE = 16'h3C02;
    localparam logic [15:0] ADDR_SEVERITY = 16'h3C04;
    localparam logic [15:0] ADDR_TIME_HI = 16'h3C06;
    localparam logic [15:0] ADDR_TIME_LO = 16'h3C08;
    localparam logic [15:0] ADDR_CYCLES = 16'h3C0A;
    localparam logic [15:0] ADDR_ON_TIME = 16'h3C0C;
    localparam logic [15:0] ADDR_CURRENT = 16'h3C12;

    // Command value for the erase and rewind controls
    localparam logic [15:0] CMD_ONE = 16'h0001;

    // Severity classes
    localparam logic [15:0] SEV_WARN = 16'h0000;
    localparam logic [15:0] SEV_ERR_QS7 = 16'h0001;
    localparam logic [15:0] SEV_ERR_QS8 = 16'h0002;
    localparam logic [15:0] SEV_FATAL = 16'h0003;
    localparam logic [15:0] SEV_FATAL_LOCK = 16'h0004;

    // Operating state targets
    localparam logic [3:0] STATE_NONE = 4'h0;
    localparam logic [3:0] STATE_QSTOP = 4'h7;
    localparam logic [3:0] STATE_REACT = 4'h8;
    localparam logic [3:0] STATE_FAULT = 4'h9;

    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SECOND_NS = 1000000000;
    localparam int CYCLES_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
    localparam logic [28:0] TIME_MAX = 29'h1FFFFFFF;
    localparam logic [15:0] U16_MAX = 16'hFFFF;

    typedef enum logic [1:0] {
        ES_IDLE = 2'b01,
        ES_CLEAR = 2'b10
    } flh_erase_state_t;

    typedef struct packed {
        logic [15:0] code;
        logic [15:0] severity;
        logic [31:0] timestamp;
        logic [15:0] on_time;
        logic [15:0] current;
        logic [15:0] cycles;
    } flh_entry_t;

    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } flh_param_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] rdata;
    } flh_param_rsp_t;

    typedef struct packed {
        logic valid;
        logic [15:0] code;
        logic [15:0] severity;
        logic [15:0] current;
    } flh_fault_t;

endpackage

// ---- core/flh_log_mem.sv ----
/*
 * Entry storage of the fault history log: one write port, one
 * asynchronous read port. Assumes the owner clears it by writing zeros.
 */
`timescale 1ns/1ps
module flh_log_mem
    import flh_pkg::*;
(
    input wire logic core_clk,
    input wire logic we,
    input wire logic [IDX_W-1:0] widx,
    input wire flh_entry_t wdata,
    input wire logic [IDX_W-1:0] ridx,
    output flh_entry_t rdata
);

    flh_entry_t mem [LOG_DEPTH];

    // No reset on the array; unwritten slots are never shown to the host
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[widx] <= wdata;
        end
    end

    assign rdata = mem[ridx];

endmodule

// ---- core/flh_ctx_timer.sv ----
/*
 * Context counters: operating seconds, power stage enable cycles and
 * seconds since the last enable. Assumes power_stage_en is on core_clk.
 */
`timescale 1ns/1ps
module flh_ctx_timer
    import flh_pkg::*;
#(
    parameter int SEC_CYCLES = CYCLES_PER_SEC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic power_stage_en,
    output logic [28:0] op_seconds,
    output logic [15:0] en_cycles,
    output logic [15:0] since_en_sec
);

    localparam int DIV_W = $clog2(SEC_CYCLES + 1);

    logic [DIV_W-1:0] div_reg, div_next;
    logic [28:0] sec_reg, sec_next;
    logic [15:0] cyc_reg, cyc_next;
    logic [15:0] since_reg, since_next;
    logic en_prev_reg, en_prev_next;
    logic tick;

    // Second divider and saturating context counters
    always_comb begin
        tick = (div_reg == DIV_W'(SEC_CYCLES - 1));
        div_next = tick ? '0 : DIV_W'(div_reg + 1'b1);
        sec_next = sec_reg;
        cyc_next = cyc_reg;
        since_next = since_reg;
        en_prev_next = power_stage_en;
        if (tick && sec_reg != TIME_MAX) begin
            sec_next = 29'(sec_reg + 1'b1);
        end
        if (power_stage_en && !en_prev_reg) begin
            since_next = '0;
            if (cyc_reg != U16_MAX) begin
                cyc_next = 16'(cyc_reg + 1'b1);
            end
        end else if (tick && power_stage_en && since_reg != U16_MAX) begin
            since_next = 16'(since_reg + 1'b1);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_reg <= '0;
            sec_reg <= '0;
            cyc_reg <= '0;
            since_reg <= '0;
            en_prev_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            sec_reg <= sec_next;
            cyc_reg <= cyc_next;
            since_reg <= since_next;
            en_prev_reg <= en_prev_next;
        end
    end

    assign op_seconds = sec_reg;
    assign en_cycles = cyc_reg;
    assign since_en_sec = since_reg;

endmodule

// ---- testbench/flh_bus_master.sv ----
/*
 * Fieldbus master model: issues one parameter access at a time.
 * Assumes the log answers on the edge that takes a request.
 */
`timescale 1ns/1ps
module flh_bus_master
    import flh_pkg::*;
(
    input wire logic core_clk,
    output flh_param_req_t param_req,
    input wire flh_param_rsp_t param_rsp
);
    initial param_req = '0;

    // Request stands for one edge; idle address and data are inverted so stale values never look valid
    task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                          output flh_param_rsp_t rsp);
        @(posedge core_clk);
        param_req <= '{req: 1'b1, wr: wr, addr: addr, wdata: wdata};
        @(posedge core_clk);
        param_req <= '{req: 1'b0, wr: ~wr, addr: ~addr, wdata: ~wdata};
        @(negedge core_clk);
        rsp = param_rsp;
    endtask

    // Host may only trust an empty log once the erase control reads zero
    task automatic poll_idle(output logic done);
        flh_param_rsp_t r;
        done = 1'b0;
        for (int n = 0; n < 40 && !done; n++) begin
            access(1'b0, ADDR_ERASE, 16'h0000, r);
            done = (r.ack === 1'b1 && r.rdata === 16'h0000);
        end
    endtask
endmodule

// ---- testbench/flh_fault_log_props.sv ----
/*
 * Checker for the fault history log: drive reaction and access port.
 * Assumes it is bound to flh_fault_log and sees only its ports.
 */
`timescale 1ns/1ps
module flh_fault_log_props
    import flh_pkg::*;
#(
    parameter int SEC_CYCLES = CYCLES_PER_SEC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire flh_param_req_t param_req,
    input wire flh_param_rsp_t param_rsp,
    input wire flh_fault_t fault_in,
    input wire logic power_stage_en,
    input wire logic fault_reset_req,
    input wire logic halt_request,
    input wire logic [3:0] target_state,
    input wire logic fault_locked
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Steps of a fault arrival and of an erase followed by its poll
    sequence s_sev(logic [15:0] c);
        fault_in.valid && fault_in.severity == c;
    endsequence
    sequence s_erase;
        param_req.req && param_req.wr && param_req.addr == ADDR_ERASE && param_req.wdata == CMD_ONE;
    endsequence
    sequence s_erase_rd;
        param_req.req && !param_req.wr && param_req.addr == ADDR_ERASE;
    endsequence

    a_warn_no_react: assert property (s_sev(SEV_WARN) ##0 !fault_reset_req |=>
        $stable(target_state) && $stable(halt_request)) else $error("warning changed reaction");
    a_class1_qstop: assert property (s_sev(SEV_ERR_QS7) ##0 target_state == STATE_NONE |=>
        halt_request && target_state == STATE_QSTOP) else $error("class 1 reaction wrong");
    a_class2_react: assert property (s_sev(SEV_ERR_QS8) ##0 target_state != STATE_FAULT |=>
        halt_request && target_state == STATE_REACT) else $error("class 2 reaction wrong");
    a_fatal_state: assert property (fault_in.valid && fault_in.severity >= SEV_FATAL |=>
        halt_request && target_state == STATE_FAULT) else $error("fatal reaction wrong");
    a_lock_set: assert property (s_sev(SEV_FATAL_LOCK) |=> fault_locked) else $error("lock not set");
    a_lock_resists: assert property (fault_locked && fault_reset_req |=>
        fault_locked && halt_request && target_state == STATE_FAULT) else $error("locked fault cleared");
    a_reset_clears: assert property (fault_reset_req && !fault_in.valid && !fault_locked |=>
        !halt_request && target_state == STATE_NONE) else $error("fault reset ignored");
    a_ack_timing: assert property (param_rsp.ack == $past(param_req.req)) else $error("ack timing");
    a_erase_taken: assert property (s_erase |=> param_rsp.ack && !param_rsp.err)
        else $error("erase write refused");
    a_code_read_only: assert property (param_req.req && param_req.wr && param_req.addr == ADDR_CODE |=>
        param_rsp.err && param_rsp.rdata == 16'h0000) else $error("code write accepted");
    a_erase_busy: assert property (s_erase ##[1:4] s_erase_rd |=> param_rsp.rdata == CMD_ONE)
        else $error("erase not busy");
endmodule

bind flh_fault_log flh_fault_log_props #(.SEC_CYCLES(SEC_CYCLES)) i_flh_fault_log_props (
    .core_clk(core_clk), .rst(rst), .param_req(param_req), .param_rsp(param_rsp),
    .fault_in(fault_in), .power_stage_en(power_stage_en), .fault_reset_req(fault_reset_req),
    .halt_request(halt_request), .target_state(target_state), .fault_locked(fault_locked));

// ---- testbench/flh_fault_log_test.sv ----
/*
 * Self-checking bench for the fault history log top.
 * Assumes the bus master model and a shortened second (10 cycles).
 */
`timescale 1ns/1ps
module flh_fault_log_test;
    import flh_pkg::*;
    localparam int SEC = 10;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    flh_param_req_t param_req;
    flh_param_rsp_t param_rsp;
    flh_fault_t fault_in = '0;
    logic power_stage_en = 1'b0;
    logic fault_reset_req = 1'b0;
    logic halt_request;
    logic fault_locked;
    logic [3:0] target_state;
    int err_count = 0;
    int compares = 0;
    int seed = 32'h0C2F0E49;
    int cyc = 0;
    int at [5];
    int ks [5];
    logic [15:0] code [5];
    logic [15:0] cur [5];
    logic [15:0] d;
    logic done;
    flh_param_rsp_t rsp;

    flh_fault_log #(.SEC_CYCLES(SEC)) i_flh_fault_log (.core_clk(core_clk), .rst(rst),
        .param_req(param_req), .param_rsp(param_rsp), .fault_in(fault_in),
        .power_stage_en(power_stage_en), .fault_reset_req(fault_reset_req),
        .halt_request(halt_request), .target_state(target_state), .fault_locked(fault_locked));
    flh_bus_master i_flh_bus_master (.core_clk(core_clk), .param_req(param_req), .param_rsp(param_rsp));

    // Clock and a cycle count since reset release for the time expectations
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= rst ? 0 : cyc + 1;
    end

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s exp %0h got %0h", name, exp, got);
        end
    endtask

    // Seconds are compared within a window: the second divider runs free, so an interval counts whole or one more
    task automatic chk_rng(string name, int lo, int hi, logic [31:0] got);
        compares++;
        if ($isunknown(got) || got < lo || got > hi) begin
            err_count++;
            $display("[ERR] %s exp %0d..%0d got %0d", name, lo, hi, got);
        end
    endtask

    task automatic rd(logic [15:0] addr, output logic [15:0] v);
        i_flh_bus_master.access(1'b0, addr, 16'h0000, rsp);
        chk("ack", 1, rsp.ack);
        chk("err", 0, rsp.err);
        v = rsp.rdata;
    endtask

    task automatic wr(logic [15:0] addr, logic [15:0] v);
        i_flh_bus_master.access(1'b1, addr, v, rsp);
        chk("ack", 1, rsp.ack);
        chk("err", 0, rsp.err);
    endtask

    // Fault pulse for one edge; fields are scrambled when not valid
    task automatic fault(logic [15:0] c, logic [15:0] s, logic [15:0] m);
        @(posedge core_clk);
        fault_in <= '{valid: 1'b1, code: c, severity: s, current: m};
        @(posedge core_clk);
        fault_in <= '{valid: 1'b0, code: ~c, severity: ~s, current: ~m};
    endtask

    function automatic logic [3:0] tgt(int c);
        case (c)
            0: return STATE_NONE;
            1: return STATE_QSTOP;
            2: return STATE_REACT;
            default: return STATE_FAULT;
        endcase
    endfunction

    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence: one fault of each class, read back, rewind, errors, erase, overrun, reset
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk("halt", 0, halt_request);
        chk("lock", 0, fault_locked);
        rd(ADDR_CODE, d);
        chk("empty code", 0, d);
        for (int i = 0; i < 5; i++) begin
            ks[i] = 12 + ($unsigned($random(seed)) % 20);
            code[i] = $random(seed);
            cur[i] = $random(seed);
            @(posedge core_clk);
            power_stage_en <= 1'b0;
            @(posedge core_clk);
            power_stage_en <= 1'b1;
            repeat (ks[i]) @(posedge core_clk);
            fault(code[i], 16'(i), cur[i]);
            at[i] = cyc;
            @(negedge core_clk);
            chk("halt", i != 0, halt_request);
            chk("target", tgt(i), target_state);
            chk("lock", i == 4, fault_locked);
            @(posedge core_clk);
            fault_reset_req <= 1'b1;
            @(posedge core_clk);
            fault_reset_req <= 1'b0;
            @(negedge core_clk);
            chk("halt after reset", i == 4, halt_request);
        end
        $display("fault classes done");
        wr(ADDR_REWIND, CMD_ONE);
        for (int i = 0; i < 5; i++) begin
            rd(ADDR_CODE, d);
            chk("code", code[i], d);
            rd(ADDR_SEVERITY, d);
            chk("severity", i, d);
            rd(ADDR_CURRENT, d);
            chk("current", cur[i], d);
            rd(ADDR_CYCLES, d);
            chk("cycles", i + 1, d);
            rd(ADDR_ON_TIME, d);
            chk_rng("since enable", ks[i] / SEC, (ks[i] + SEC - 1) / SEC, d);
            rd(ADDR_TIME_HI, d);
            chk("time hi", 0, d);
            rd(ADDR_TIME_LO, d);
            chk_rng("time", (at[i] - 3) / SEC, (at[i] + 3) / SEC, d);
        end
        $display("read back done");
        rd(ADDR_CODE, d);
        chk("past end code", 0, d);
        rd(ADDR_SEVERITY, d);
        chk("past end severity", 0, d);
        fault(16'hBEEF, SEV_WARN, 16'h0010);
        rd(ADDR_CODE, d);
        chk("pointer kept", 16'hBEEF, d);
        wr(ADDR_ERASE, 16'h0002);
        wr(ADDR_REWIND, CMD_ONE);
        rd(ADDR_CODE, d);
        chk("rewound code", code[0], d);
        i_flh_bus_master.access(1'b1, ADDR_CODE, 16'h1234, rsp);
        chk("code write err", 1, rsp.err);
        i_flh_bus_master.access(1'b0, 16'h3C00, 16'h0000, rsp);
        chk("unmapped err", 1, rsp.err);
        rd(ADDR_REWIND, d);
        chk("rewind reads", 0, d);
        $display("access errors done");
        wr(ADDR_ERASE, CMD_ONE);
        rd(ADDR_ERASE, d);
        chk("erase busy", CMD_ONE, d);
        i_flh_bus_master.poll_idle(done);
        chk("erase done", 1, done);
        if (!done) begin
            end_sim();
        end
        wr(ADDR_REWIND, CMD_ONE);
        rd(ADDR_CODE, d);
        chk("erased code", 0, d);
        $display("erase done");
        // Seventeen faults overrun the ring; the first one must be gone
        for (int i = 0; i < 17; i++) begin
            fault(16'h0100 + 16'(i), SEV_WARN, 16'(i));
        end
        wr(ADDR_REWIND, CMD_ONE);
        for (int i = 1; i < 18; i++) begin
            rd(ADDR_CODE, d);
            chk("wrapped code", (i < 17) ? 16'h0100 + 16'(i) : 16'h0000, d);
        end
        $display("wrap done");
        // Reset in mid-run releases the lock and empties the log
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk("lock after rst", 0, fault_locked);
        chk("halt after rst", 0, halt_request);
        rd(ADDR_CODE, d);
        chk("code after rst", 0, d);
        $display("mid-run reset done");
        end_sim();
    end
endmodule
